// [design/sebp_pkg.sv]
/*
 * package for the shared external bus pin block: widths, owner codes,
 * static bus width codes and the user-side request carriers.
 * assumes nothing of its surroundings.
 */
package sebp_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 64;
    localparam int CFG_DATA_W = 16;
    localparam int SDRAM_ADDR_LO = 5;
    localparam int SDRAM_ADDR_W = ADDR_W - SDRAM_ADDR_LO;
    localparam int CFG_W = ADDR_W + CFG_DATA_W;

    // static bus width per accessed channel
    localparam logic [1:0] SBW_32 = 2'h0;
    localparam logic [1:0] SBW_16 = 2'h1;
    localparam logic [1:0] SBW_8 = 2'h2;

    // address shift applied for each width (byte address to pin)
    localparam int SHIFT_32 = 2;
    localparam int SHIFT_16 = 1;
    localparam int SHIFT_8 = 0;

    localparam logic ISOLATE = 1'b1;
    localparam logic CONNECT = 1'b0;

    typedef enum logic [2:0] {
        OWN_NONE = 3'h1,
        OWN_DRAM = 3'h2,
        OWN_STAT = 3'h4
    } sebp_owner_t;

    typedef struct packed {
        logic req;
        logic [SDRAM_ADDR_W-1:0] addr;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } sebp_dram_req_t;

    typedef struct packed {
        logic req;
        logic [1:0] width;
        logic [ADDR_W+1:0] addr;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } sebp_stat_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CFG_DATA_W-1:0] data;
    } sebp_boot_cfg_t;
endpackage

// [design/sebp_pins.sv]
/*
 * shared external bus pin control: steers the address and data pins to
 * the dram controller or the static bus controller, catches boot
 * configuration during reset and drives the isolation output.
 * assumes both controllers request through plain structs, never both at
 * once; dram wins if they do. pin wires are resolved by the testbench.
 */
`timescale 1ns/1ps

// Functional notes
// R1: route 20-bit address and 64-bit data to dram or static controller.
// R2: address pins stay inputs during reset, driven after release.
// R3: address pins are sampled as boot configuration while reset holds.
// R4: data pins 15:0 are sampled as boot configuration while reset holds.
// R5: pins chosen by configuration take configured state even in reset.
// R6: dram cycles drive only address pins 19 down to 5.
// R7: static bus address mapping follows the channel data bus width.
// R8: isolation output high separates, low connects non-dram devices.
// R9: external buffers open or close following the isolation output.
// R10: connect only for static bus accesses; isolate in reset and dram.
module sebp_pins (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire sebp_pkg::sebp_dram_req_t dram_req_i,
    input wire sebp_pkg::sebp_stat_req_t stat_req_i,
    output logic [sebp_pkg::DATA_W-1:0] rdata_o,
    output sebp_pkg::sebp_boot_cfg_t boot_cfg_o,
    output sebp_pkg::sebp_owner_t owner_o,
    input wire logic [sebp_pkg::ADDR_W-1:0] addr_pin_i,
    output logic [sebp_pkg::ADDR_W-1:0] addr_pin_o,
    output logic [sebp_pkg::ADDR_W-1:0] addr_pin_oe_o,
    input wire logic [sebp_pkg::DATA_W-1:0] data_pin_i,
    output logic [sebp_pkg::DATA_W-1:0] data_pin_o,
    output logic [sebp_pkg::DATA_W-1:0] data_pin_oe_o,
    output logic bus_isolate_n_o
);
    import sebp_pkg::*;

    function automatic logic [ADDR_W-1:0] stat_map(input logic [1:0] w,
                                                   input logic [ADDR_W+1:0] a);
        logic [ADDR_W+1:0] s;
        s = a;
        unique case (w)
            SBW_32: s = a >> SHIFT_32;
            SBW_16: s = a >> SHIFT_16;
            SBW_8: s = a >> SHIFT_8;
            default: s = a >> SHIFT_32;
        endcase
        return s[ADDR_W-1:0];
    endfunction

    sebp_owner_t own_d;
    logic [ADDR_W-1:0] addr_d;
    logic [ADDR_W-1:0] aoe_d;
    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] doe_d;
    logic iso_d;

    wire dram_sel = dram_req_i.req;
    wire stat_sel = stat_req_i.req & ~dram_req_i.req;

    // R1: owner select, R6: dram uses upper address bits only
    wire [ADDR_W-1:0] dram_addr = {dram_req_i.addr, {SDRAM_ADDR_LO{1'b0}}};
    wire [ADDR_W-1:0] dram_aoe = {{SDRAM_ADDR_W{1'b1}}, {SDRAM_ADDR_LO{1'b0}}};
    // R7: width dependent mapping
    wire [ADDR_W-1:0] stat_addr = stat_map(stat_req_i.width, stat_req_i.addr);

    always_comb begin
        own_d = OWN_NONE;
        addr_d = '0;
        aoe_d = '1;
        data_d = '0;
        doe_d = '0;
        // R10: isolated unless a static access
        iso_d = ISOLATE;
        if (dram_sel) begin
            own_d = OWN_DRAM;
            addr_d = dram_addr;
            aoe_d = dram_aoe;
            data_d = dram_req_i.wdata;
            doe_d = {DATA_W{dram_req_i.wr}};
        end else if (stat_sel) begin
            own_d = OWN_STAT;
            addr_d = stat_addr;
            data_d = stat_req_i.wdata;
            doe_d = {DATA_W{stat_req_i.wr}};
            // R8: connect non-dram devices
            iso_d = CONNECT;
        end
    end

    // R2: async reset forces inputs; enables rise after release
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_pin_oe_o <= '0;
            addr_pin_o <= '0;
            data_pin_oe_o <= '0;
            data_pin_o <= '0;
            owner_o <= OWN_NONE;
            // R5: isolation takes its state during reset too
            bus_isolate_n_o <= ISOLATE;
        end else begin
            addr_pin_oe_o <= aoe_d;
            addr_pin_o <= addr_d;
            data_pin_oe_o <= doe_d;
            data_pin_o <= data_d;
            owner_o <= own_d;
            bus_isolate_n_o <= iso_d;
        end
    end

    // R3: R4: sample straps on every clock while reset holds
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            boot_cfg_o.addr <= addr_pin_i;
            boot_cfg_o.data <= data_pin_i[CFG_DATA_W-1:0];
        end
        rdata_o <= data_pin_i;
    end

    // R2: address stays released through reset
    chk_addr_in_reset: assert property (@(posedge sys_clk_i) // R2
        sys_rst_i |-> addr_pin_oe_o == '0)
        else $error("address driven during reset");

    // R2: address driven one cycle after release
    chk_addr_out_after: assert property (@(posedge sys_clk_i) // R2
        $fell(sys_rst_i) |=> addr_pin_oe_o != '0)
        else $error("address not driven after reset");

    // R3: strap captured from address pins
    chk_cfg_addr_cap: assert property (@(posedge sys_clk_i) // R3
        sys_rst_i |=> boot_cfg_o.addr == $past(addr_pin_i))
        else $error("address strap not captured");

    // R4: strap captured from low data pins
    chk_cfg_data_cap: assert property (@(posedge sys_clk_i) // R4
        sys_rst_i |=> boot_cfg_o.data == $past(data_pin_i[CFG_DATA_W-1:0]))
        else $error("data strap not captured");

    // R5: isolation held high in reset
    chk_iso_reset: assert property (@(posedge sys_clk_i) // R5
        sys_rst_i |-> bus_isolate_n_o == ISOLATE)
        else $error("isolation low in reset");

    sequence dram_cycle;
        dram_req_i.req ##1 1'b1;
    endsequence

    // R6: low address bits idle in dram cycles
    chk_dram_low_bits: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R6
        dram_cycle |-> addr_pin_oe_o[SDRAM_ADDR_LO-1:0] == '0
                       && owner_o == OWN_DRAM)
        else $error("dram drives low address bits");

    // R7: width 32 shifts by two
    chk_stat_map32: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R7
        (stat_sel && stat_req_i.width == SBW_32)
        |=> addr_pin_o == $past(stat_req_i.addr[ADDR_W+1:SHIFT_32]))
        else $error("static address mapping wrong");

    // R8: R10: connect exactly during static ownership
    chk_iso_owner: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R8
        (bus_isolate_n_o == CONNECT) == (owner_o == OWN_STAT))
        else $error("isolation disagrees with owner");

    // R10: dram access keeps devices isolated
    chk_iso_dram: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R10
        dram_req_i.req |=> bus_isolate_n_o == ISOLATE)
        else $error("isolation dropped for dram");

    sequence stat_write;
        stat_sel && stat_req_i.wr;
    endsequence

    sequence any_read;
        (dram_sel && !dram_req_i.wr) || (stat_sel && !stat_req_i.wr);
    endsequence

    // R1: dram write data on the pins
    chk_dram_wdata: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R1
        (dram_sel && dram_req_i.wr)
        |=> data_pin_o == $past(dram_req_i.wdata) && data_pin_oe_o == '1)
        else $error("dram write data not on pins");

    // R1: static write data on the pins
    chk_stat_wdata: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R1
        stat_write |=> data_pin_o == $past(stat_req_i.wdata) && owner_o == OWN_STAT)
        else $error("static write data not on pins");

    // R1: reads leave data undriven
    chk_read_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R1
        any_read |=> data_pin_oe_o == '0)
        else $error("data pins driven on a read");

    // R1: read data one cycle late
    chk_rdata_copy: assert property (@(posedge sys_clk_i) // R1
        1'b1 |=> rdata_o == $past(data_pin_i))
        else $error("read data not copied from pins");

    // R7: width 16 shifts by one
    chk_stat_map16: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R7
        (stat_sel && stat_req_i.width == SBW_16)
        |=> addr_pin_o == $past(stat_req_i.addr[ADDR_W:SHIFT_16]))
        else $error("width 16 address mapping wrong");

    // R7: width 8 keeps byte address
    chk_stat_map8: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R7
        (stat_sel && stat_req_i.width == SBW_8)
        |=> addr_pin_o == $past(stat_req_i.addr[ADDR_W-1:SHIFT_8]))
        else $error("width 8 address mapping wrong");

    // R8: static access connects devices
    chk_stat_connect: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R8
        stat_sel |=> bus_isolate_n_o == CONNECT)
        else $error("isolation kept for static access");

    // R10: idle bus stays isolated
    chk_idle_isolate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R10
        !(dram_sel || stat_sel) |=> bus_isolate_n_o == ISOLATE && owner_o == OWN_NONE)
        else $error("isolation dropped while idle");

    // R2: upper address always driven
    chk_addr_driven: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R2
        !sys_rst_i |=> addr_pin_oe_o[ADDR_W-1:SDRAM_ADDR_LO] == '1)
        else $error("address pins released out of reset");
endmodule

// [verif/sebp_ext_model.sv]
/*
 * far side model: pulled-up address and data lines, boot straps during
 * reset, a device answering reads through the isolation buffer.
 * assumes the bench feeds it the pin outputs and enables of the block.
 */
`timescale 1ns/1ps
module sebp_ext_model #(
    parameter logic [19:0] STRAP_A = 20'h0,
    parameter logic [15:0] STRAP_D = 16'h0,
    parameter logic [63:0] RD_VAL = 64'h0
) (
    input wire logic rst_i,
    input wire logic iso_n_i,
    input wire logic [19:0] a_val_i,
    input wire logic [19:0] a_oe_i,
    input wire logic [63:0] d_val_i,
    input wire logic [63:0] d_oe_i,
    output logic [19:0] a_pin_o,
    output logic [63:0] d_pin_o
);
    // straps on the pins while reset holds
    wire [19:0] a_ext = rst_i ? STRAP_A : 20'hfffff;
    // buffer passes data only while connected, else the pull-ups win
    wire [63:0] d_ext = rst_i ? {48'hffffffffffff, STRAP_D} :
        (iso_n_i ? 64'hffffffffffffffff : RD_VAL);
    assign a_pin_o = (a_oe_i & a_val_i) | (~a_oe_i & a_ext);
    assign d_pin_o = (d_oe_i & d_val_i) | (~d_oe_i & d_ext);
endmodule

// [verif/shared_ext_bus_pin_control_test.sv]
/*
 * self-checking bench for the shared pin block with the far side model.
 * assumes the block's registered one-cycle answer to each request.
 */
`timescale 1ns/1ps
module shared_ext_bus_pin_control_test;
    import sebp_pkg::*;
    localparam logic [19:0] SA = 20'h5a3c1;
    localparam logic [15:0] SD = 16'hc3a5;
    localparam logic [63:0] RV = 64'h0123456789abcdef;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    sebp_dram_req_t dreq = '0;
    sebp_stat_req_t sreq = '0;
    logic [63:0] rdata, dpo, dpoe, dpi;
    logic [19:0] apo, apoe, api;
    sebp_boot_cfg_t cfg;
    sebp_owner_t owner;
    logic iso_n;
    int mismatches = 0;
    int checks_done = 0;

    sebp_pins sebp_pins_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .dram_req_i(dreq), .stat_req_i(sreq), .rdata_o(rdata), .boot_cfg_o(cfg),
        .owner_o(owner), .addr_pin_i(api), .addr_pin_o(apo), .addr_pin_oe_o(apoe),
        .data_pin_i(dpi), .data_pin_o(dpo), .data_pin_oe_o(dpoe),
        .bus_isolate_n_o(iso_n));
    sebp_ext_model #(.STRAP_A(SA), .STRAP_D(SD), .RD_VAL(RV)) sebp_ext_model_inst (
        .rst_i(sys_rst_i), .iso_n_i(iso_n), .a_val_i(apo), .a_oe_i(apoe),
        .d_val_i(dpo), .d_oe_i(dpoe), .a_pin_o(api), .d_pin_o(dpi));

    initial forever #12.5 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic test_reset();
        chk(apoe, 64'h0);
        chk(cfg, {SA, SD});
        chk(iso_n, 64'h1);
        @(posedge sys_clk_i) sys_rst_i <= 1'b0;
        step();
        chk(apoe, 64'hfffff);
        chk(cfg, {SA, SD});
        $display("reset test done");
    endtask

    task automatic test_dram();
        @(posedge sys_clk_i) dreq <= '{1'b1, 15'h4b2d, 1'b1, RV};
        step();
        chk(apo, {15'h4b2d, 5'h0});
        chk(apoe, {15'h7fff, 5'h0});
        chk(dpo, RV);
        chk(owner, OWN_DRAM);
        chk(iso_n, 64'h1);
        @(posedge sys_clk_i) dreq <= '0;
        $display("dram test done");
    endtask

    task automatic test_static();
        logic [21:0] a;
        a = 22'h2abcd4;
        // width code 3 is illegal and must map like 32
        for (int w = 0; w < 4; w++) begin
            @(posedge sys_clk_i) sreq <= '{1'b1, 2'(w), a, 1'b1, ~RV};
            step();
            chk(apo, 20'(a >> ((w == 3) ? 2 : 2 - w)));
            chk(iso_n, 64'h0);
            chk(owner, OWN_STAT);
            chk(dpo, ~RV);
            chk(dpoe, {64{1'b1}});
            @(posedge sys_clk_i) sreq.wr <= 1'b0;
            step();
            chk(dpoe, 64'h0);
            @(posedge sys_clk_i) sreq <= '0;
            #1;
            chk(rdata, RV);
            step();
            chk(iso_n, 64'h1);
        end
        $display("static test done");
    endtask

    task automatic test_priority();
        @(posedge sys_clk_i) begin
            dreq <= '{1'b1, 15'h0001, 1'b0, 64'h0};
            sreq <= '{1'b1, 2'h2, 22'h3ffff, 1'b1, RV};
        end
        step();
        chk(owner, OWN_DRAM);
        chk(iso_n, 64'h1);
        chk(apo, 20'h00020);
        @(posedge sys_clk_i) begin
            dreq <= '0;
            sreq <= '0;
        end
        $display("priority test done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        // a reset edge at time zero settles the pins before the first clock
        sys_rst_i <= 1'b1;
        repeat (7) @(posedge sys_clk_i);
        #1;
        test_reset();
        test_dram();
        test_static();
        test_priority();
        end_of_test();
    end

    // the whole run is well under 100 cycles
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        mismatches++;
        end_of_test();
    end
endmodule
